/* rtl/rwx_pkg.sv */
`default_nettype none
package rwx_pkg;

	// Configuration space offsets
	localparam logic [7:0] OFF_ROM_BASE  = 8'h30;
	localparam logic [7:0] OFF_XB_DN1    = 8'h98;
	localparam logic [7:0] OFF_XB_UP0    = 8'hA4;
	// Control/status space offsets of the translated bases
	localparam logic [7:0] CSR_XB_DN1    = 8'h6C;
	localparam logic [7:0] CSR_XB_UP0    = 8'h78;

	// Field positions
	localparam int ROM_EN_BIT    = 0;
	localparam int ROM_BASE_LO   = 12;
	localparam int ROM_SETUP_LO  = 11;
	localparam int ROM_SETUP_HI  = 23;
	localparam int XB_LO         = 6;

	localparam int ROM_BASE_W    = 20;
	localparam int XB_W          = 26;

	localparam logic [ROM_BASE_W-1:0] ROM_BASE_RST = 20'h00000;
	localparam logic [XB_W-1:0]       XB_RST       = 26'h0000000;

	typedef enum logic [1:0] {
		RWX_IDLE  = 2'b00,
		RWX_ROMRD = 2'b01,
		RWX_REPLY = 2'b10
	} rwx_state_t;

	// Register access request
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic        csr;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} rwx_reg_req_t;

	// Forwarding request through a translated window
	typedef struct packed {
		logic        valid;
		logic        upstream;
		logic [31:0] addr;
	} rwx_fwd_req_t;

	typedef struct packed {
		rwx_state_t            st;
		logic [ROM_BASE_W-1:0] rom_base;
		logic                  rom_dec_en;
		logic [XB_W-1:0]       xb_dn1;
		logic [XB_W-1:0]       xb_up0;
		logic [31:0]           rdata;
		logic                  rack;
		logic                  rom_req;
		logic [31:0]           rom_addr;
		logic                  rd_ack;
		logic [31:0]           rd_data;
		logic                  claim;
		logic                  xlat_valid;
		logic                  xlat_upstream;
		logic [31:0]           xlat_addr;
	} rwx_state_s_t;

endpackage
`default_nettype wire

/* rtl/rwx_rom_window_xlat.sv */
`timescale 1ns/1ps
`default_nettype none
module rwx_rom_window_xlat (
	// Clock and reset
	input  wire logic                  clock,
	input  wire logic                  rst_n,
	// Setup values, preloaded before host configuration
	input  wire logic [31:0]           rom_setup,
	input  wire logic [31:0]           dn1_bar_mask,
	input  wire logic [31:0]           up0_bar_mask,
	input  wire logic                  mem_space_en,
	// Register access
	input  wire rwx_pkg::rwx_reg_req_t reg_req,
	output logic [31:0]                reg_rdata,
	output logic                       reg_rack,
	// Primary memory read
	input  wire logic                  pm_rd_valid,
	input  wire logic [31:0]           pm_rd_addr,
	output logic                       pm_claim,
	output logic                       pm_rd_ack,
	output logic [31:0]                pm_rd_data,
	// Parallel ROM port
	output logic                       rom_rd_req,
	output logic [31:0]                rom_rd_addr,
	input  wire logic                  rom_rd_done,
	input  wire logic [31:0]           rom_rd_data,
	// Forwarding through translated windows
	input  wire rwx_pkg::rwx_fwd_req_t fwd_req,
	output logic                       xlat_valid,
	output logic                       xlat_upstream,
	output logic [31:0]                xlat_addr
);

	rwx_pkg::rwx_state_s_t s_q;
	rwx_pkg::rwx_state_s_t s_d;

	logic [31:0] rom_mask;
	logic        rom_win_en;
	logic        rom_hit;
	logic [31:0] rom_base_full;
	logic [31:0] xb_dn1_full;
	logic [31:0] xb_up0_full;

	// Base bit n is writable when setup bit n is set; above the setup field
	// the bits follow whether the window exists at all.
	function automatic logic [31:0] rom_mask_f(input logic [31:0] setup);
		logic [31:0] m;
		m = 32'h00000000;
		for (int i = rwx_pkg::ROM_BASE_LO; i < 32; i++)
		begin
			if (i <= rwx_pkg::ROM_SETUP_HI)
				m[i] = setup[i];
			else
				m[i] = |setup[rwx_pkg::ROM_SETUP_HI:rwx_pkg::ROM_SETUP_LO];
		end
		return m;
	endfunction

	// Base part taken from the translated base, offset kept from the request
	function automatic logic [31:0] xlat_f(input logic [31:0] addr, input logic [31:0] base,
			input logic [31:0] mask);
		return (addr & ~mask) | (base & mask);
	endfunction

	always_comb
	begin
		rom_mask      = rom_mask_f(rom_setup);
		rom_win_en    = |rom_mask;
		rom_base_full = {s_q.rom_base, 12'h000} & rom_mask;
		xb_dn1_full   = {s_q.xb_dn1, 6'h00};
		xb_up0_full   = {s_q.xb_up0, 6'h00};
		// Memory enable and decode enable both needed to claim
		rom_hit = pm_rd_valid && s_q.rom_dec_en && mem_space_en && rom_win_en
			&& (((pm_rd_addr ^ rom_base_full) & rom_mask) == 32'h00000000);
	end

	always_comb
	begin
		// Strobes are one-cycle pulses; data outputs hold until replaced
		s_d            = s_q;
		s_d.rack       = 1'b0;
		s_d.claim      = 1'b0;
		s_d.rd_ack     = 1'b0;
		s_d.xlat_valid = 1'b0;

		// Register writes: reserved and fixed bits are simply not stored
		if (reg_req.wr)
		begin
			if (!reg_req.csr && reg_req.addr == rwx_pkg::OFF_ROM_BASE)
			begin
				s_d.rom_base   = reg_req.wdata[31:rwx_pkg::ROM_BASE_LO]
					& rom_mask[31:rwx_pkg::ROM_BASE_LO];
				s_d.rom_dec_en = reg_req.wdata[rwx_pkg::ROM_EN_BIT] & rom_win_en;
			end
			if ((!reg_req.csr && reg_req.addr == rwx_pkg::OFF_XB_DN1)
				|| (reg_req.csr && reg_req.addr == rwx_pkg::CSR_XB_DN1))
				s_d.xb_dn1 = reg_req.wdata[31:rwx_pkg::XB_LO];
			if ((!reg_req.csr && reg_req.addr == rwx_pkg::OFF_XB_UP0)
				|| (reg_req.csr && reg_req.addr == rwx_pkg::CSR_XB_UP0))
				s_d.xb_up0 = reg_req.wdata[31:rwx_pkg::XB_LO];
		end

		if (reg_req.rd)
		begin
			s_d.rack  = 1'b1;
			s_d.rdata = 32'h00000000;
			if (!reg_req.csr)
			begin
				case (reg_req.addr)
					rwx_pkg::OFF_ROM_BASE: s_d.rdata = rom_base_full
						| {31'h00000000, s_q.rom_dec_en & rom_win_en};
					rwx_pkg::OFF_XB_DN1:   s_d.rdata = xb_dn1_full;
					rwx_pkg::OFF_XB_UP0:   s_d.rdata = xb_up0_full;
					default:               s_d.rdata = 32'h00000000;
				endcase
			end
			else
			begin
				case (reg_req.addr)
					rwx_pkg::CSR_XB_DN1: s_d.rdata = xb_dn1_full;
					rwx_pkg::CSR_XB_UP0: s_d.rdata = xb_up0_full;
					default:             s_d.rdata = 32'h00000000;
				endcase
			end
		end

		// Shrinking the setup later must not leave a stale enable behind
		if (!rom_win_en)
			s_d.rom_dec_en = 1'b0;

		// ROM read sequence; one read outstanding at a time
		// A hit that arrives while busy is dropped; the host has to retry
		case (s_q.st)
			rwx_pkg::RWX_IDLE:
			begin
				if (rom_hit)
				begin
					s_d.claim    = 1'b1;
					s_d.rom_req  = 1'b1;
					s_d.rom_addr = pm_rd_addr & ~rom_mask;
					s_d.st       = rwx_pkg::RWX_ROMRD;
				end
			end
			rwx_pkg::RWX_ROMRD:
			begin
				if (rom_rd_done)
				begin
					s_d.rom_req = 1'b0;
					s_d.rd_data = rom_rd_data;
					s_d.rd_ack  = 1'b1;
					s_d.st      = rwx_pkg::RWX_REPLY;
				end
			end
			rwx_pkg::RWX_REPLY:
			begin
				// Quiet cycle before the next decode, so the host can drop its request
				s_d.st = rwx_pkg::RWX_IDLE;
			end
			default:
			begin
				s_d.rom_req = 1'b0;
				s_d.st      = rwx_pkg::RWX_IDLE;
			end
		endcase

		// Translation: downstream window uses one base, upstream the other
		if (fwd_req.valid)
		begin
			s_d.xlat_valid    = 1'b1;
			s_d.xlat_upstream = fwd_req.upstream;
			s_d.xlat_addr     = fwd_req.upstream
				? xlat_f(fwd_req.addr, xb_up0_full, up0_bar_mask)
				: xlat_f(fwd_req.addr, xb_dn1_full, dn1_bar_mask);
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_q            <= '0;
			s_q.st         <= rwx_pkg::RWX_IDLE;
			s_q.rom_base   <= rwx_pkg::ROM_BASE_RST;
			s_q.rom_dec_en <= 1'b0;
			s_q.xb_dn1     <= rwx_pkg::XB_RST;
			s_q.xb_up0     <= rwx_pkg::XB_RST;
		end
		else
			s_q <= s_d;
	end

	assign reg_rdata     = s_q.rdata;
	assign reg_rack      = s_q.rack;
	assign pm_claim      = s_q.claim;
	assign pm_rd_ack     = s_q.rd_ack;
	assign pm_rd_data    = s_q.rd_data;
	assign rom_rd_req    = s_q.rom_req;
	assign rom_rd_addr   = s_q.rom_addr;
	assign xlat_valid    = s_q.xlat_valid;
	assign xlat_upstream = s_q.xlat_upstream;
	assign xlat_addr     = s_q.xlat_addr;

endmodule
`default_nettype wire

/* tb/rwx_rom_mdl.sv */
`timescale 1ns/1ps
`default_nettype none
module rwx_rom_mdl (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	// ROM port, memory side
	input  wire logic        rom_rd_req,
	input  wire logic [31:0] rom_rd_addr,
	output logic             rom_rd_done,
	output logic [31:0]      rom_rd_data
);
	logic [1:0] n_q;
	logic hold_q;
	// Offset bits pick the wait, so prompt and slow replies both occur
	wire logic go = rom_rd_req && !hold_q && n_q == rom_rd_addr[1:0];
	always_ff @(posedge clock or negedge rst_n)
		if (!rst_n)
			{n_q, hold_q, rom_rd_done, rom_rd_data} <= '0;
		else
		begin
			rom_rd_done <= go;
			// Toggles outside done so a stale sample never matches
			rom_rd_data <= go ? {rom_rd_addr[15:0], rom_rd_addr[31:16]} ^ 32'h5A5A5A5A : ~rom_rd_data;
			hold_q <= rom_rd_req && (hold_q || go);
			n_q <= rom_rd_req ? n_q + 2'h1 : 2'h0;
		end
endmodule
`default_nettype wire

/* tb/rwx_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module rwx_sva (
	// Clock and reset
	input wire logic                  clock,
	input wire logic                  rst_n,
	// Setup
	input wire logic                  mem_space_en,
	input wire logic [31:0]           rom_setup,
	// Register access
	input wire rwx_pkg::rwx_reg_req_t reg_req,
	input wire logic                  reg_rack,
	input wire logic [31:0]           reg_rdata,
	// Primary memory read
	input wire logic                  pm_rd_valid,
	input wire logic                  pm_claim,
	input wire logic                  pm_rd_ack,
	input wire logic [31:0]           pm_rd_data,
	// Parallel ROM port
	input wire logic                  rom_rd_req,
	input wire logic [31:0]           rom_rd_addr,
	input wire logic                  rom_rd_done,
	input wire logic [31:0]           rom_rd_data,
	// Forwarding
	input wire rwx_pkg::rwx_fwd_req_t fwd_req,
	input wire logic                  xlat_valid,
	input wire logic                  xlat_upstream
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	wire logic base_rd = reg_req.rd && !reg_req.csr && reg_req.addr == 8'h30;
	property p_rack; reg_req.rd |=> reg_rack; endproperty
	a_rack: assert property (p_rack) else $error("no rack");
	property p_low; reg_rack |-> reg_rdata[5:1] == 5'h00; endproperty
	a_low: assert property (p_low) else $error("low bits set");
	property p_rom; base_rd |=> (reg_rdata[23:12] & ~rom_setup[23:12]) == 12'h000; endproperty
	a_rom: assert property (p_rom) else $error("fixed bit set");
	property p_dis; base_rd && rom_setup[23:11] == 13'h0000 |=> reg_rdata == 32'h00000000; endproperty
	a_dis: assert property (p_dis) else $error("disabled base");
	property p_claim; pm_claim |-> $past(pm_rd_valid && mem_space_en) && rom_rd_req; endproperty
	a_claim: assert property (p_claim) else $error("bad claim");
	property p_hold; rom_rd_req && !rom_rd_done |=> rom_rd_req && $stable(rom_rd_addr); endproperty
	a_hold: assert property (p_hold) else $error("read dropped");
	property p_ack;
		rom_rd_req && rom_rd_done |=> pm_rd_ack && !rom_rd_req && pm_rd_data == $past(rom_rd_data);
	endproperty
	a_ack: assert property (p_ack) else $error("bad ack");
	property p_fwd; fwd_req.valid |=> xlat_valid && xlat_upstream == $past(fwd_req.upstream); endproperty
	a_fwd: assert property (p_fwd) else $error("bad forward");
	c_rom: cover property (pm_rd_ack);
	c_up: cover property (xlat_valid && xlat_upstream);
	c_en: cover property (reg_rack && reg_rdata[0]);
endmodule
bind rwx_rom_window_xlat rwx_sva u_sva (
	.clock         (clock),
	.rst_n         (rst_n),
	.mem_space_en  (mem_space_en),
	.rom_setup     (rom_setup),
	.reg_req       (reg_req),
	.reg_rack      (reg_rack),
	.reg_rdata     (reg_rdata),
	.pm_rd_valid   (pm_rd_valid),
	.pm_claim      (pm_claim),
	.pm_rd_ack     (pm_rd_ack),
	.pm_rd_data    (pm_rd_data),
	.rom_rd_req    (rom_rd_req),
	.rom_rd_addr   (rom_rd_addr),
	.rom_rd_done   (rom_rd_done),
	.rom_rd_data   (rom_rd_data),
	.fwd_req       (fwd_req),
	.xlat_valid    (xlat_valid),
	.xlat_upstream (xlat_upstream)
);
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic mem_space_en = 1'b0;
	logic pm_rd_valid = 1'b0;
	logic [31:0] rom_setup = 32'h0, dn1_bar_mask = 32'h0, up0_bar_mask = 32'h0, pm_rd_addr = 32'h0;
	rwx_pkg::rwx_reg_req_t reg_req = '0;
	rwx_pkg::rwx_fwd_req_t fwd_req = '0;
	logic reg_rack, pm_claim, pm_rd_ack, rom_rd_req, rom_rd_done, xlat_valid, xlat_upstream;
	logic [31:0] reg_rdata, pm_rd_data, rom_rd_addr, rom_rd_data, xlat_addr, w, m, o;
	logic [31:0] xb [2] = '{32'h0, 32'h0};
	// Translated bases by config then control space, ROM base, one unmapped place
	logic [8:0] ro [6] = '{9'h098, 9'h0A4, 9'h16C, 9'h178, 9'h030, 9'h044};
	int bad_count = 0;
	int checked = 0;
	rwx_rom_window_xlat dut (.*);
	rwx_rom_mdl u_rom (.*);
	always #2.5 clock = ~clock;
	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		bad_count += int'(g !== e);
		if (g !== e) $display("BAD %s exp %h got %h", n, e, g);
	endtask
	task automatic acc(input logic wr, input logic [8:0] a, input logic [31:0] d);
		@(posedge clock) reg_req <= '{wr, !wr, a[8], a[7:0], d};
		@(posedge clock) reg_req <= '0;
		#1 cmp("rack", {31'h0, !wr}, {31'h0, reg_rack});
		if (!wr) cmp("rdata", d, reg_rdata);
	endtask
	task automatic rom(input logic [31:0] a, input logic hit);
		o = a & ~m;
		@(posedge clock) {pm_rd_valid, pm_rd_addr} <= {1'b1, a};
		@(posedge clock) pm_rd_valid <= 1'b0;
		#1 cmp("claim", {31'h0, hit}, {31'h0, pm_claim});
		cmp("romreq", {31'h0, hit}, {31'h0, rom_rd_req});
		if (hit) cmp("raddr", o, rom_rd_addr);
		for (int i = 0; i < 9 && hit && pm_rd_ack !== 1'b1; i++) @(posedge clock) #1;
		if (hit) cmp("ack", 32'h1, {31'h0, pm_rd_ack});
		if (hit) cmp("romdata", {o[15:0], o[31:16]} ^ 32'h5A5A5A5A, pm_rd_data);
		repeat (3) @(posedge clock);
	endtask
	task automatic fwd(input logic up, input logic [31:0] a);
		m = up ? up0_bar_mask : dn1_bar_mask;
		@(posedge clock) fwd_req <= '{1'b1, up, a};
		@(posedge clock) fwd_req <= '0;
		#1 cmp("xlat", a & ~m | xb[up] & m, xlat_addr);
		cmp("xvalid", {30'h0, 1'b1, up}, {30'h0, xlat_valid, xlat_upstream});
	endtask
	task automatic print_verdict(input int extra);
		bad_count += extra;
		if (bad_count == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial #50000 print_verdict(1);
	initial
	begin
		void'($urandom(32'h826A40C1));
		dn1_bar_mask <= $urandom;
		up0_bar_mask <= $urandom;
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		foreach (ro[k]) acc(1'b0, ro[k], 32'h0);
		mem_space_en <= 1'b1;
		acc(1'b1, 9'h030, 32'hFFFFFFFF);
		acc(1'b0, 9'h030, 32'h0);
		rom(32'h0, 1'b0);
		rom_setup <= 32'h00F00800;
		for (int k = 0; k < 4; k++)
		begin
			// Hit, memory space off, decode off, address outside window
			w = $urandom & 32'hFFFFFFFE | {31'h0, k != 2};
			mem_space_en <= k != 1;
			acc(1'b1, 9'h030, w);
			m = {{8{|rom_setup[23:11]}}, rom_setup[23:12], 12'h000};
			acc(1'b0, 9'h030, w & m | {31'h0, w[0]});
			rom(k == 3 ? w ^ 32'h80000000 : w & m | $urandom & ~m, k == 0);
		end
		for (int j = 0; j < 4; j++)
		begin
			w = $urandom;
			xb[j % 2] = w & 32'hFFFFFFC0;
			acc(1'b1, ro[j], w);
			acc(1'b0, ro[j ^ 2], xb[j % 2]);
			fwd(j[0], $urandom);
			fwd(!j[0], $urandom);
		end
		// Second reset with the window still open: every base and the enable clear
		@(posedge clock) rst_n <= 1'b0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		foreach (ro[k]) acc(1'b0, ro[k], 32'h0);
		print_verdict(0);
	end
endmodule
`default_nettype wire
